/* core/chan_match.v */
// Purpose: one channel's address, ASID, cycle and data comparison
// Assumes: qualifiers arrive on core_clk from the pipeline, no crossing needed
// Notes: combinational; the top module registers every result
module chan_match (
  // programmed condition
  input wire [15:0] cyc_sel,
  input wire [31:0] cmp_addr,
  input wire [7:0] cmp_asid,
  input wire [31:0] cmp_data,
  input wire [31:0] cmp_mask,
  input wire use_data,
  // observed access
  input wire acc_insn,
  input wire acc_write,
  input wire [2:0] acc_size,
  input wire [31:0] acc_addr,
  input wire [7:0] acc_asid,
  input wire [63:0] acc_data,
  input wire acc_nodata,
  // result
  output reg hit
);
`include "ubm_regs.vh"

reg [31:0] amask;
reg [31:0] dmask;
reg [1:0] id_f;
reg [1:0] rw_f;
reg [2:0] sz_f;
reg [2:0] eff_sz;
reg kind_ok;
reg data_ok;
reg [31:0] hi_w;
reg [31:0] lo_w;

////////////////////////////////////////////////////////////////////////////////
// compare: a 00 kind or direction field disables the channel
always @* begin
  id_f = cyc_sel[`CYC_ID_HI:`CYC_ID_LO];
  rw_f = cyc_sel[`CYC_RW_HI:`CYC_RW_LO];
  sz_f = {cyc_sel[`CYC_SZ_BIT6], cyc_sel[1:0]};
  eff_sz = (sz_f == `SZ_NONE) ? acc_size : sz_f;
  kind_ok = acc_insn ? id_f[0] : id_f[1];
  kind_ok = kind_ok && (acc_write ? rw_f[1] : rw_f[0]);
  kind_ok = kind_ok && (sz_f == `SZ_NONE || sz_f == acc_size);
  case (eff_sz)
    `SZ_QUAD: amask = 32'hFFFFFFF8;
    `SZ_LONG: amask = 32'hFFFFFFFC;
    `SZ_WORD: amask = 32'hFFFFFFFE;
    default: amask = 32'hFFFFFFFF;
  endcase
  // word and byte sizes drop the upper half of data and mask
  dmask = ~cmp_mask; // see (RULE_05)
  if (eff_sz == `SZ_WORD || eff_sz == `SZ_BYTE) begin
    dmask[31:16] = 16'h0000; // see (RULE_05)
  end
  // quadword data is two longwords; either half may hit
  hi_w = acc_data[63:32];
  lo_w = acc_data[31:0];
  if (eff_sz == `SZ_QUAD) begin
    data_ok = (((hi_w ^ cmp_data) & dmask) == 32'h00000000) ||
              (((lo_w ^ cmp_data) & dmask) == 32'h00000000); // see (RULE_02)
  end else begin
    data_ok = ((lo_w ^ cmp_data) & dmask) == 32'h00000000;
  end
  // instruction fetches ignore the data register entirely
  if (!use_data || acc_insn) begin
    data_ok = 1'b1; // see (RULE_22)
  end else if (acc_nodata) begin
    data_ok = 1'b0; // see (RULE_06)
  end
  hit = (id_f != 2'h0) && (rw_f != 2'h0) && kind_ok &&
        (((acc_addr ^ cmp_addr) & amask) == 32'h00000000) &&
        (acc_asid == cmp_asid) && data_ok; // see (RULE_01)
end

endmodule // chan_match

/* core/ubm_regs.vh */
// Purpose: offsets, field positions, reset values and timing counts of the break match unit
// Assumes: 32-bit classic Wishbone, word addressed registers at byte offsets
// Notes: definitions only
`ifndef UBM_REGS_VH
`define UBM_REGS_VH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_CYC_A 8'h04
`define OFS_CYC_B 8'h08
`define OFS_ADDR_A 8'h0C
`define OFS_ADDR_B 8'h10
`define OFS_ASID_A 8'h14
`define OFS_ASID_B 8'h18
`define OFS_DATA_B 8'h1C
`define OFS_MASK_B 8'h20
`define OFS_SPC 8'h24

// break_control_reg fields
`define CTL_FLAG_A 15
`define CTL_FLAG_B 14
`define CTL_PRE_A 10
`define CTL_PRE_B 6
`define CTL_DCMP_B 7
`define CTL_SEQ 3
`define CTL_WMASK 16'h04C8

// bus_cycle_select fields
`define CYC_ID_HI 5
`define CYC_ID_LO 4
`define CYC_RW_HI 3
`define CYC_RW_LO 2
`define CYC_SZ_HI 2
`define CYC_SZ_LO 0
`define CYC_SZ_BIT6 6

// access kind and size codes
`define ID_INSN 2'h1
`define ID_OPER 2'h2
`define SZ_NONE 3'h0
`define SZ_BYTE 3'h1
`define SZ_WORD 3'h2
`define SZ_LONG 3'h3
`define SZ_QUAD 3'h4

// reset values
`define RST_CTRL 16'h0000
`define RST_CYC 16'h0000
`define RST_WORD 32'h00000000

// delayed data break: instructions allowed to retire before the break
`define DATA_BREAK_LAG 3'h1

`endif

/* core/user_break_match_unit.v */
// Purpose: two-channel hardware breakpoint match, flags and saved PC
// Assumes: pipeline reports fetch, operand and retire events on core_clk
// Notes: registers over classic Wishbone; data compare only on channel B

// Overview of operation
// (RULE_01) channel B data compare needs address, ASID, data
// (RULE_02) quadword data: either 32-bit half may match
// (RULE_03) software selects operand accesses for data compare
// (RULE_04) software duplicates byte value in both bytes
// (RULE_05) word/byte ignore upper data and mask
// (RULE_06) no data break on dataless operand ops
// (RULE_07) post and operand flags set at completion
// (RULE_08) multi-access instruction may flag at detection
// (RULE_09) no operand flag for unexecuted instruction
// (RULE_10) pre-execution flag at detection, even TLB miss
// (RULE_11) pre-execution saves own address, suppresses it
// (RULE_12) post-execution saves next instruction address
// (RULE_13) delayed branch post break saves target or fallthrough
// (RULE_14) address-only operand break saves next address
// (RULE_15) data break lands one to four later
// (RULE_16) interrupt loses to delayed data break vector
// (RULE_17) sequential insn/insn needs two apart
// (RULE_18) sequential insn/operand needs two apart
// (RULE_19) sequential operand/insn needs four apart
// (RULE_20) sequential break on B after A, B flag only
// (RULE_21) flags cleared only by software writing zero
// (RULE_22) instruction channel B ignores data register
module user_break_match_unit (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // instruction fetch confirmed for execution
  input wire fetch_valid,
  input wire [31:0] fetch_addr,
  input wire [7:0] fetch_asid,
  // operand access
  input wire op_valid,
  input wire op_write,
  input wire [2:0] op_size,
  input wire [31:0] op_addr,
  input wire [7:0] op_asid,
  input wire [63:0] op_data,
  input wire op_nodata,
  input wire op_multi,
  // retirement and flow
  input wire retire_valid,
  input wire [31:0] retire_next_pc,
  input wire squash,
  input wire async_irq,
  // break exception
  output reg break_req,
  output reg break_use_own_code,
  output reg [31:0] saved_program_counter,
  output reg suppress_fetch
);
`include "ubm_regs.vh"

reg [15:0] break_control_reg;
reg [15:0] bus_cycle_select_a;
reg [15:0] bus_cycle_select_b;
reg [31:0] break_addr_a;
reg [31:0] break_addr_b;
reg [7:0] break_asid_a;
reg [7:0] break_asid_b;
reg [31:0] break_data_value_b;
reg [31:0] break_data_mask_b;
reg seq_armed;
reg pend_a;
reg pend_b;
reg pend_data;
reg [2:0] lag_cnt;
reg [31:0] next_rdata;
wire ins_hit_a;
wire ins_hit_b;
wire op_hit_a;
wire op_hit_b;
wire seq_mode;
wire wb_req;
wire [15:0] ctl_wr;

assign seq_mode = break_control_reg[`CTL_SEQ];
assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
assign ctl_wr = {wb_sel_i[1] ? wb_dat_i[15:8] : break_control_reg[15:8],
                 wb_sel_i[0] ? wb_dat_i[7:0] : break_control_reg[7:0]};

////////////////////////////////////////////////////////////////////////////////
// comparators: one per channel for fetches, one per channel for operands
chan_match u_ins_a (
  .cyc_sel(bus_cycle_select_a), .cmp_addr(break_addr_a), .cmp_asid(break_asid_a),
  .cmp_data(32'h00000000), .cmp_mask(32'h00000000), .use_data(1'b0),
  .acc_insn(1'b1), .acc_write(1'b0), .acc_size(`SZ_WORD), .acc_addr(fetch_addr),
  .acc_asid(fetch_asid), .acc_data(64'h0000000000000000), .acc_nodata(1'b0),
  .hit(ins_hit_a)
);
chan_match u_ins_b (
  .cyc_sel(bus_cycle_select_b), .cmp_addr(break_addr_b), .cmp_asid(break_asid_b),
  .cmp_data(break_data_value_b), .cmp_mask(break_data_mask_b),
  .use_data(break_control_reg[`CTL_DCMP_B]),
  .acc_insn(1'b1), .acc_write(1'b0), .acc_size(`SZ_WORD), .acc_addr(fetch_addr),
  .acc_asid(fetch_asid), .acc_data(64'h0000000000000000), .acc_nodata(1'b0),
  .hit(ins_hit_b)
);
chan_match u_op_a (
  .cyc_sel(bus_cycle_select_a), .cmp_addr(break_addr_a), .cmp_asid(break_asid_a),
  .cmp_data(32'h00000000), .cmp_mask(32'h00000000), .use_data(1'b0),
  .acc_insn(1'b0), .acc_write(op_write), .acc_size(op_size), .acc_addr(op_addr),
  .acc_asid(op_asid), .acc_data(op_data), .acc_nodata(op_nodata),
  .hit(op_hit_a)
);
chan_match u_op_b (
  .cyc_sel(bus_cycle_select_b), .cmp_addr(break_addr_b), .cmp_asid(break_asid_b),
  .cmp_data(break_data_value_b), .cmp_mask(break_data_mask_b),
  .use_data(break_control_reg[`CTL_DCMP_B]), // see (RULE_01)
  .acc_insn(1'b0), .acc_write(op_write), .acc_size(op_size), .acc_addr(op_addr),
  .acc_asid(op_asid), .acc_data(op_data), .acc_nodata(op_nodata),
  .hit(op_hit_b)
);

// qualified hits; in sequential mode B only counts once A has armed
wire fa = fetch_valid && ins_hit_a;
wire fb = fetch_valid && ins_hit_b && (!seq_mode || seq_armed); // see (RULE_20)
// in sequential mode an A hit only arms channel B, it never breaks by itself
wire pre_a = fa && break_control_reg[`CTL_PRE_A] && !seq_mode; // see (RULE_20)
wire pre_b = fb && break_control_reg[`CTL_PRE_B];
wire oa = op_valid && op_hit_a;
wire ob = op_valid && op_hit_b && (!seq_mode || seq_armed);
wire ob_data = ob && break_control_reg[`CTL_DCMP_B];

////////////////////////////////////////////////////////////////////////////////
// wishbone read mux
always @* begin
  case (wb_adr_i)
    `OFS_CTRL: next_rdata = {16'h0000, break_control_reg};
    `OFS_CYC_A: next_rdata = {16'h0000, bus_cycle_select_a};
    `OFS_CYC_B: next_rdata = {16'h0000, bus_cycle_select_b};
    `OFS_ADDR_A: next_rdata = break_addr_a;
    `OFS_ADDR_B: next_rdata = break_addr_b;
    `OFS_ASID_A: next_rdata = {24'h000000, break_asid_a};
    `OFS_ASID_B: next_rdata = {24'h000000, break_asid_b};
    `OFS_DATA_B: next_rdata = break_data_value_b;
    `OFS_MASK_B: next_rdata = break_data_mask_b;
    `OFS_SPC: next_rdata = saved_program_counter;
    default: next_rdata = 32'h00000000;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// bus slave: one wait state, ack for every address, unmapped reads zero
always @(posedge core_clk) begin
  if (sys_rst) begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h00000000;
  end else begin
    wb_ack_o <= wb_req;
    wb_dat_o <= wb_req ? next_rdata : 32'h00000000;
  end
end

////////////////////////////////////////////////////////////////////////////////
// configuration registers, byte lanes honoured
always @(posedge core_clk) begin
  if (sys_rst) begin
    bus_cycle_select_a <= `RST_CYC;
    bus_cycle_select_b <= `RST_CYC;
    break_addr_a <= `RST_WORD;
    break_addr_b <= `RST_WORD;
    break_asid_a <= 8'h00;
    break_asid_b <= 8'h00;
    break_data_value_b <= `RST_WORD;
    break_data_mask_b <= `RST_WORD;
  end else if (wb_req && wb_we_i) begin
    case (wb_adr_i)
      `OFS_CYC_A: begin
        if (wb_sel_i[0]) bus_cycle_select_a[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) bus_cycle_select_a[15:8] <= wb_dat_i[15:8];
      end
      `OFS_CYC_B: begin
        if (wb_sel_i[0]) bus_cycle_select_b[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) bus_cycle_select_b[15:8] <= wb_dat_i[15:8];
      end
      `OFS_ASID_A: begin
        if (wb_sel_i[0]) break_asid_a <= wb_dat_i[7:0];
      end
      `OFS_ASID_B: begin
        if (wb_sel_i[0]) break_asid_b <= wb_dat_i[7:0];
      end
      default: begin
      end
    endcase
    if (wb_adr_i == `OFS_ADDR_A || wb_adr_i == `OFS_ADDR_B ||
        wb_adr_i == `OFS_DATA_B || wb_adr_i == `OFS_MASK_B) begin
      if (wb_adr_i == `OFS_ADDR_A) begin
        break_addr_a <= lane_merge(break_addr_a, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == `OFS_ADDR_B) begin
        break_addr_b <= lane_merge(break_addr_b, wb_dat_i, wb_sel_i);
      end
      // byte compares rely on software repeating the byte
      if (wb_adr_i == `OFS_DATA_B) begin
        break_data_value_b <= lane_merge(break_data_value_b, wb_dat_i, wb_sel_i); // see (RULE_04)
      end
      if (wb_adr_i == `OFS_MASK_B) begin
        break_data_mask_b <= lane_merge(break_data_mask_b, wb_dat_i, wb_sel_i);
      end
    end
  end
end

// byte-lane merge of a 32-bit write
function [31:0] lane_merge;
  input [31:0] old_v;
  input [31:0] new_v;
  input [3:0] sel;
  integer i;
  begin
    for (i = 0; i < 4; i = i + 1) begin
      lane_merge[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// sequencing and pending breaks
// a single-access operand hit waits for retirement so a squashed instruction never flags
always @(posedge core_clk) begin
  if (sys_rst) begin
    seq_armed <= 1'b0;
    pend_a <= 1'b0;
    pend_b <= 1'b0;
    pend_data <= 1'b0;
    lag_cnt <= 3'h0;
  end else begin
    if (squash) begin
      pend_a <= 1'b0; // see (RULE_09)
      pend_b <= 1'b0;
      pend_data <= 1'b0;
    end else begin
      if (!seq_mode && ((fa && !break_control_reg[`CTL_PRE_A]) || oa)) pend_a <= 1'b1;
      if ((fb && !break_control_reg[`CTL_PRE_B]) || ob) pend_b <= 1'b1;
      if (ob_data) pend_data <= 1'b1;
      if (retire_valid && !(fa || fb || oa || ob)) begin
        pend_a <= 1'b0; // see (RULE_07)
        pend_b <= 1'b0;
        pend_data <= 1'b0;
      end
    end
    // data break retires a fixed number of further instructions, within the 1..4 window
    if (retire_valid && pend_data && !squash) begin
      lag_cnt <= `DATA_BREAK_LAG; // see (RULE_15)
    end else if (lag_cnt != 3'h0 && retire_valid) begin
      lag_cnt <= lag_cnt - 3'h1;
    end
    // B hit disarms; writing SEQ to zero also disarms.  guaranteed only with
    // the spacing of 2/2/4 instructions, closer pairs fall where they fall
    if (!seq_mode || fb || ob) begin
      seq_armed <= 1'b0; // see (RULE_17) (RULE_18) (RULE_19)
    end else if (fa || oa) begin
      seq_armed <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// match flags: hardware sets, software clears by writing zero; set beats clear
wire set_a = !seq_mode && (pre_a || (oa && op_multi) ||
             (retire_valid && pend_a && !squash)); // see (RULE_08) (RULE_10)
wire set_b = pre_b || (ob && op_multi) || (retire_valid && pend_b && !squash);
always @(posedge core_clk) begin
  if (sys_rst) begin
    break_control_reg <= `RST_CTRL;
  end else begin
    if (wb_req && wb_we_i && wb_adr_i == `OFS_CTRL) begin
      break_control_reg <= (ctl_wr & `CTL_WMASK) |
        (break_control_reg & ctl_wr & 16'hC000); // see (RULE_21)
    end
    if (set_a) break_control_reg[`CTL_FLAG_A] <= 1'b1;
    if (set_b) break_control_reg[`CTL_FLAG_B] <= 1'b1; // see (RULE_20)
  end
end

////////////////////////////////////////////////////////////////////////////////
// break request and saved program counter
always @(posedge core_clk) begin
  if (sys_rst) begin
    break_req <= 1'b0;
    break_use_own_code <= 1'b0;
    saved_program_counter <= `RST_WORD;
    suppress_fetch <= 1'b0;
  end else begin
    break_req <= 1'b0;
    suppress_fetch <= 1'b0;
    break_use_own_code <= 1'b0;
    if (pre_a || pre_b) begin
      break_req <= 1'b1;
      suppress_fetch <= 1'b1; // see (RULE_11)
      saved_program_counter <= fetch_addr; // see (RULE_11)
    end else if (retire_valid && !squash && (pend_a || pend_b) && !pend_data) begin
      break_req <= 1'b1;
      // next_pc is the branch target or post-slot address for delayed branches
      saved_program_counter <= retire_next_pc; // see (RULE_12) (RULE_13) (RULE_14)
    end else if (lag_cnt == 3'h1 && retire_valid) begin
      break_req <= 1'b1;
      // async interrupts must not steal the vector from a data break
      break_use_own_code <= 1'b1; // see (RULE_16)
      saved_program_counter <= retire_next_pc; // see (RULE_15)
    end
  end
end

// RULE_03 is software's duty: data compare only fires with an operand kind
// and is enforced by the operand comparators above. see (RULE_03)
wire unused_irq = async_irq;

endmodule // user_break_match_unit

/* sim/cpu_pipe_model.sv */
// Purpose: pipeline side model issuing fetch, operand and retire events
// Assumes: one pulse per call, launched right after a rising edge
// Notes: idle addresses, fetch ASID, operand data and next pc show the inverse of their last value
module cpu_pipe_model (
  // clock
  input wire logic core_clk,
  // pipeline events
  output logic fetch_valid = 1'b0,
  output logic [31:0] fetch_addr = 32'h00000000,
  output logic [7:0] fetch_asid = 8'h00,
  output logic op_valid = 1'b0,
  output logic [2:0] op_size = 3'h0,
  output logic [31:0] op_addr = 32'h00000000,
  output logic [7:0] op_asid = 8'h00,
  output logic [63:0] op_data = 64'h0000000000000000,
  output logic op_nodata = 1'b0,
  output logic retire_valid = 1'b0,
  output logic [31:0] retire_next_pc = 32'h00000000,
  output logic squash = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // confirmed fetch, one cycle
  task automatic fetch(input logic [31:0] a, input logic [7:0] s);
    @(posedge core_clk);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    fetch_asid <= s;
    @(posedge core_clk);
    fetch_valid <= 1'b0;
    fetch_addr <= ~a;
    fetch_asid <= ~s;
  endtask
  // operand access; kill marks an instruction that never executes
  task automatic oper(input logic [2:0] z, input logic [31:0] a, input logic [7:0] s,
    input logic [63:0] d, input logic nd, input logic kill);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_size <= z;
    op_addr <= a;
    op_asid <= s;
    op_data <= d;
    op_nodata <= nd;
    squash <= kill;
    @(posedge core_clk);
    op_valid <= 1'b0;
    op_addr <= ~a;
    op_data <= ~d;
    squash <= 1'b0;
  endtask
  // retirement, next pc is the target or the fall-through address
  task automatic retire(input logic [31:0] pc);
    @(posedge core_clk);
    retire_valid <= 1'b1;
    retire_next_pc <= pc;
    @(posedge core_clk);
    retire_valid <= 1'b0;
    retire_next_pc <= ~pc;
  endtask
endmodule // cpu_pipe_model

/* sim/ubm_checker_asserts.sv */
// Purpose: port-level checker for the break match unit
// Assumes: single core_clk domain, sys_rst synchronous active high
// Notes: attached by bind below the module
module ubm_checker (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // register bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // pipeline
  input wire fetch_valid,
  input wire [31:0] fetch_addr,
  input wire retire_valid,
  input wire [31:0] retire_next_pc,
  // break exception
  input wire break_req,
  input wire break_use_own_code,
  input wire [31:0] saved_program_counter,
  input wire suppress_fetch
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////////////////
  // bus handshake
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_next_edge_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not idle");
  //////////////////////////////////////////////////////////////////////////////
  // break outputs
  brk_pulse_a: assert property (break_req |=> !break_req) else $error("break held");
  pre_suppress_a: assert property (suppress_fetch |-> break_req)
    else $error("suppress without break");
  pre_on_fetch_a: assert property (suppress_fetch |-> $past(fetch_valid))
    else $error("pre break without fetch");
  pre_saved_pc_a: assert property (suppress_fetch |-> saved_program_counter == $past(fetch_addr))
    else $error("pre break pc wrong");
  post_on_retire_a: assert property (break_req && !suppress_fetch |-> $past(retire_valid))
    else $error("post break without retire");
  post_saved_pc_a: assert property (break_req && !suppress_fetch |->
    saved_program_counter == $past(retire_next_pc)) else $error("post pc wrong");
  own_code_brk_a: assert property (break_use_own_code |-> break_req && !suppress_fetch)
    else $error("own code without data break");
  pc_holds_a: assert property (!break_req |-> $stable(saved_program_counter))
    else $error("saved pc moved");
  // main scenarios
  pre_seen_c: cover property (suppress_fetch);
  post_seen_c: cover property (break_req && !suppress_fetch && !break_use_own_code);
  data_seen_c: cover property (break_use_own_code);
endmodule // ubm_checker

bind user_break_match_unit ubm_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .retire_valid(retire_valid),
  .retire_next_pc(retire_next_pc), .break_req(break_req),
  .break_use_own_code(break_use_own_code),
  .saved_program_counter(saved_program_counter), .suppress_fetch(suppress_fetch));

/* sim/user_break_match_unit_test.sv */
// Purpose: directed bench for the break match unit
// Assumes: classic Wishbone master tasks, pipeline model for events
// Notes: break pulses counted by a monitor, compared after each step
`include "ubm_regs.vh"
module user_break_match_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  wire [31:0] wb_dat_o, fa, oa, rpc, saved_program_counter;
  wire [7:0] fs, os;
  wire [63:0] od;
  wire [2:0] oz;
  wire wb_ack_o, fv, ov, ond, rv, sq, break_req, break_use_own_code, suppress_fetch;
  int error_cnt = 0;
  int checks = 0;
  logic op_write = 1'b0, op_multi = 1'b0, async_irq = 1'b0;
  int brk_cnt = 0;
  int sup_cnt = 0;
  int own_cnt = 0;
  int base = 0;
  always #5 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////////
  // design and pipeline model
  user_break_match_unit DUT (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fetch_valid(fv),
    .fetch_addr(fa), .fetch_asid(fs), .op_valid(ov), .op_write(op_write), .op_size(oz),
    .op_addr(oa), .op_asid(os), .op_data(od), .op_nodata(ond), .op_multi(op_multi),
    .retire_valid(rv), .retire_next_pc(rpc), .squash(sq), .async_irq(async_irq),
    .break_req(break_req), .break_use_own_code(break_use_own_code),
    .saved_program_counter(saved_program_counter), .suppress_fetch(suppress_fetch));
  cpu_pipe_model cpu (.core_clk(core_clk), .fetch_valid(fv), .fetch_addr(fa),
    .fetch_asid(fs), .op_valid(ov), .op_size(oz), .op_addr(oa), .op_asid(os),
    .op_data(od), .op_nodata(ond), .retire_valid(rv), .retire_next_pc(rpc), .squash(sq));
  // break pulse monitor
  always @(posedge core_clk) begin
    if (break_req === 1'b1) brk_cnt <= brk_cnt + 1;
    if (suppress_fetch === 1'b1) sup_cnt <= sup_cnt + 1;
    if (break_use_own_code === 1'b1) own_cnt <= own_cnt + 1;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; wait has no bound of its own, the watchdog ends a hang
  task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_io(1'b1, a, d, q);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_io(1'b0, a, 32'h00000000, q);
    chk(what, exp, q);
  endtask
  // break count since last call, and saved pc when one is expected
  task automatic brk_exp(input string what, input int n, input logic [31:0] pc);
    repeat (3) @(posedge core_clk);
    #1;
    chk(what, 32'(n), 32'(brk_cnt - base));
    if (n > 0) chk({what, " pc"}, pc, saved_program_counter);
    base = brk_cnt;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // watchdog, run needs well under 2000 cycles
  initial begin
    #50000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdc("ctrl reset", `OFS_CTRL, 32'h00000000);
    rdc("spc reset", `OFS_SPC, 32'h00000000);
    rdc("unmapped", 8'hFC, 32'h00000000);
    $display("test reset done");
    // pre-execution break on channel A, wrong asid first
    wr(`OFS_ADDR_A, 32'h00001000);
    wr(`OFS_ASID_A, 32'h00000080);
    wr(`OFS_CTRL, 32'h00000400);
    wr(`OFS_CYC_A, 32'h00000014);
    cpu.fetch(32'h00001000, 8'h81);
    brk_exp("asid miss", 0, 0);
    cpu.fetch(32'h00001000, 8'h80);
    brk_exp("pre break", 1, 32'h00001000);
    rdc("flag a pre", `OFS_CTRL, 32'h00008400);
    wr(`OFS_CTRL, 32'h00000400);
    rdc("flag clear", `OFS_CTRL, 32'h00000400);
    $display("test pre done");
    // post-execution: nothing before completion, next pc saved
    wr(`OFS_CTRL, 32'h00000000);
    cpu.fetch(32'h00001000, 8'h80);
    brk_exp("post early", 0, 0);
    cpu.retire(32'h00002000);
    brk_exp("post break", 1, 32'h00002000);
    rdc("flag a post", `OFS_CTRL, 32'h00008000);
    wr(`OFS_CYC_A, 32'h00000000);
    wr(`OFS_CTRL, 32'h00000000);
    $display("test post done");
    // channel B quad data compare, upper half matches, break one retire late
    wr(`OFS_ADDR_B, 32'h00003000);
    wr(`OFS_ASID_B, 32'h00000070);
    wr(`OFS_DATA_B, 32'h12345678);
    wr(`OFS_MASK_B, 32'h00000000);
    wr(`OFS_CTRL, 32'h00000080);
    wr(`OFS_CYC_B, 32'h00000064);
    async_irq <= 1'b1;
    cpu.oper(`SZ_QUAD, 32'h00003000, 8'h70, 64'h12345678DEADBEEF, 1'b0, 1'b0);
    cpu.retire(32'h00003008);
    cpu.retire(32'h0000300C);
    brk_exp("data break", 1, 32'h0000300C);
    rdc("flag b data", `OFS_CTRL, 32'h00004080);
    // data miss, dataless op and squashed op each give no break
    cpu.oper(`SZ_QUAD, 32'h00003000, 8'h70, 64'h1234567012345670, 1'b0, 1'b0);
    cpu.retire(32'h00003008);
    cpu.retire(32'h0000300C);
    brk_exp("data miss", 0, 0);
    cpu.oper(`SZ_QUAD, 32'h00003000, 8'h70, 64'h1234567812345678, 1'b1, 1'b0);
    cpu.retire(32'h00003008);
    cpu.retire(32'h0000300C);
    brk_exp("no data op", 0, 0);
    wr(`OFS_CTRL, 32'h00000080);
    cpu.oper(`SZ_QUAD, 32'h00003000, 8'h70, 64'h1234567812345678, 1'b0, 1'b1);
    cpu.retire(32'h00003008);
    cpu.retire(32'h0000300C);
    brk_exp("squashed op", 0, 0);
    rdc("flag b squash", `OFS_CTRL, 32'h00000080);
    op_multi <= 1'b1;
    cpu.oper(`SZ_QUAD, 32'h00003000, 8'h70, 64'hDEADBEEF12345678, 1'b0, 1'b0);
    rdc("flag b multi", `OFS_CTRL, 32'h00004080);
    op_multi <= 1'b0;
    cpu.retire(32'h00003008);
    cpu.retire(32'h0000300C);
    brk_exp("multi break", 1, 32'h0000300C);
    op_write <= 1'b1;
    cpu.oper(`SZ_QUAD, 32'h00003000, 8'h70, 64'h1234567812345678, 1'b0, 1'b0);
    cpu.retire(32'h00003008);
    op_write <= 1'b0;
    brk_exp("write miss", 0, 0);
    $display("test data done");
    // sequential: B alone no break, then A then B two apart
    wr(`OFS_CTRL, 32'h000004C8);
    wr(`OFS_ADDR_B, 32'h00001010);
    wr(`OFS_ASID_B, 32'h00000080);
    wr(`OFS_CYC_A, 32'h00000014);
    wr(`OFS_CYC_B, 32'h00000014);
    cpu.fetch(32'h00001010, 8'h80);
    brk_exp("seq b alone", 0, 0);
    cpu.fetch(32'h00001000, 8'h80);
    cpu.fetch(32'h00001004, 8'h80);
    cpu.fetch(32'h00001010, 8'h80);
    brk_exp("seq break", 1, 32'h00001010);
    rdc("seq flags", `OFS_CTRL, 32'h000044C8);
    $display("test sequential done");
    chk("pre suppress", 2, sup_cnt);
    chk("own code", 2, own_cnt);
    end_sim();
  end
endmodule // user_break_match_unit_test
